// >>> ipid_pkg.sv
// Purpose: shared constants for the four-pin interrupting input port
// Assumes: 250 MHz core clock, APB register access with 32-bit data
// Notes: offsets are byte addresses, one aligned word per register
package ipid_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int IPID_PINS = 4;        // port width
  localparam int IPID_AW = 8;          // decoded address bits

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IPID_OFS_LEVELS = 8'h00;   // input_pin_levels, read only
  localparam logic [7:0] IPID_OFS_ENABLES = 8'h04;  // pin_irq_enables
  localparam logic [7:0] IPID_OFS_FLAGS = 8'h08;    // pin_irq_flags, write one to clear
  localparam logic [7:0] IPID_OFS_POLARITY = 8'h0c; // pin_edge_polarity
  localparam logic [7:0] IPID_OFS_BYPASS = 8'h10;   // debounce_bypass_bits
  localparam logic [7:0] IPID_OFS_PULLDIS = 8'h14;  // pull_disable_bits
  localparam logic [7:0] IPID_OFS_CTRL = 8'h18;     // prescaler_control / wake options
  localparam logic [7:0] IPID_OFS_EVT = 8'h1c;      // event status, clear on read
  localparam logic [7:0] IPID_OFS_EVTMASK = 8'h20;  // event status mask

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int IPID_CTRL_DEBOUNCE_CLOCK_SELECT = 0;  // debounce_clock_select
  localparam int IPID_CTRL_WAKE = 1;    // sleep_wake_enable

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] IPID_RST_ENABLES = 4'h0;
  localparam logic [3:0] IPID_RST_FLAGS = 4'h0;
  localparam logic [3:0] IPID_RST_POLARITY = 4'h0;
  localparam logic [3:0] IPID_RST_BYPASS = 4'h0;
  localparam logic [3:0] IPID_RST_PULLDIS = 4'h0;
  localparam logic [1:0] IPID_RST_CTRL = 2'h0;
  localparam logic [3:0] IPID_RST_EVT = 4'h0;
  localparam logic [3:0] IPID_RST_EVTMASK = 4'h0;

  // ----------------------------------------------------------------
  // timing: debounce tap periods in ns, converted to core cycles
  // ----------------------------------------------------------------
  localparam int IPID_CLK_PERIOD_NS = 4;            // 250 MHz
  localparam int IPID_TAP_SLOW_NS = 7812500;        // 128 Hz tap
  localparam int IPID_TAP_FAST_NS = 976562;         // 1024 Hz tap
  localparam int IPID_TAP_SLOW_CYC = IPID_TAP_SLOW_NS / IPID_CLK_PERIOD_NS;
  localparam int IPID_TAP_FAST_CYC = IPID_TAP_FAST_NS / IPID_CLK_PERIOD_NS;

endpackage

// >>> ipid_port.sv
// Purpose: four-pin input port with debounce, edge interrupts and wake
// Assumes: pins asynchronous to core_clk; sleep and reset match are same-clock
// Notes: registers reached over APB, zero wait states
//
// Operation
// (R1) software reads each pin level anytime
// (R2) every option held separately per pin; debounce select and wake enable are single bits shared by all pins
// (R3) sleep drops pulls unless wake enabled
// (R4) wake-enabled sleep exits on reset match
// (R5) debounce needs stability over two ticks
// (R6) bypass bit picks direct or debounced
// (R7) debounce tap select: slow or fast
// (R8) polarity bit picks interrupt edge
// (R9) interrupt enables reset to zero
// (R10) masked edges discarded, never pending
// (R11) flags reset zero, write one clears
// (R12) edges taken on polarity-adjusted signal
// (R13) software masks before changing polarity
// (R14) pull active only when not disabled
// (R15) pins 0-2 debounced to branch conditions
// (R16) pins 0,3 clock the event counter
// (R17) pin 3 raw drives millisecond counter
// (R18) irq while enabled flag set
// (R19) pins synchronised, edges by compare
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module ipid_port
  import ipid_pkg::*;
#(
  parameter int SLOW_CYC = IPID_TAP_SLOW_CYC, // shorten in simulation
  parameter int FAST_CYC = IPID_TAP_FAST_CYC, // shorten in simulation
  parameter logic [3:0] PULLUP_MASK = 4'h0,   // pullup_mask_option per pin
  parameter logic [3:0] PULLDN_MASK = 4'hf    // pulldown_mask_option per pin
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IPID_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] input_pins,
  input wire logic sleep_mode,
  input wire logic reset_match,
  output logic [3:0] pullup_en,
  output logic [3:0] pulldown_en,
  output logic wake,
  output logic [2:0] branch_condition,
  output logic [1:0] event_clock,
  output logic millisecond_counter_ctl,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [3:0] sync1_ff, sync2_ff, sync3_ff; // pin synchroniser chain
  logic [3:0] pin_level_ff;                 // accepted pin level
  logic [3:0] deb_samp_ff;                  // level at last debounce tick
  logic [3:0] deb_ff;                       // debounced level
  logic [3:0] pol_prev_ff;                  // previous polarity-adjusted value
  logic [3:0] enables_ff;                   // pin_irq_enables
  logic [3:0] flags_ff;                     // pin_irq_flags
  logic [3:0] polarity_ff;                  // pin_edge_polarity
  logic [3:0] bypass_ff;                    // debounce_bypass_bits
  logic [3:0] pulldis_ff;                   // pull_disable_bits
  logic [1:0] ctrl_ff;                      // debounce select, wake enable
  logic [3:0] evt_ff;                       // event status, clear on read
  logic [3:0] evtmask_ff;                   // event status mask
  logic [31:0] tap_cnt_ff;                  // debounce tap divider
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [3:0] pullup_ff, pulldown_ff;
  logic wake_ff, irq_ff, msc_ff;
  logic [2:0] branch_ff;
  logic [1:0] evclk_ff;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic tap_tick;           // one-cycle debounce clock edge
  logic [31:0] tap_limit;   // divider end count for chosen tap
  logic inputs_active;      // inputs live outside plain sleep
  logic [3:0] sel_level;    // bypass-selected level
  logic [3:0] pol_level;    // polarity-adjusted level
  logic [3:0] edge_seen;    // rising edge of adjusted level
  logic [3:0] flag_set;     // enabled edges this cycle
  logic [3:0] flag_clr;     // write-one-to-clear mask this cycle
  logic acc, wr_acc, rd_acc, mapped;
  logic [31:0] nxt_prdata;

  // address decode for the error flag only; the read mux decodes paddr itself
  function automatic logic ipid_mapped(input logic [IPID_AW-1:0] a);
    unique case (a)
      IPID_OFS_LEVELS, IPID_OFS_ENABLES, IPID_OFS_FLAGS, IPID_OFS_POLARITY,
      IPID_OFS_BYPASS, IPID_OFS_PULLDIS, IPID_OFS_CTRL, IPID_OFS_EVT,
      IPID_OFS_EVTMASK: ipid_mapped = 1'b1;
      default: ipid_mapped = 1'b0;
    endcase
  endfunction

  assign acc = psel & penable & pready_ff;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign mapped = ipid_mapped(paddr);
  // inputs deactivated in sleep unless wake is enabled
  assign inputs_active = ~sleep_mode | ctrl_ff[IPID_CTRL_WAKE]; // R3
  // debounce clock choice
  assign tap_limit = ctrl_ff[IPID_CTRL_DEBOUNCE_CLOCK_SELECT] ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1); // R7
  assign tap_tick = (tap_cnt_ff >= tap_limit);
  // per-pin bypass and polarity, each bit its own choice
  assign sel_level = (bypass_ff & pin_level_ff) | (~bypass_ff & deb_ff); // R2 R6
  assign pol_level = sel_level ^ polarity_ff; // R8 R12
  assign edge_seen = pol_level & ~pol_prev_ff; // R19
  // masked edges are dropped here, nothing is held pending
  assign flag_set = edge_seen & enables_ff; // R10
  // only a completed write to the flag word clears; zeros leave bits alone
  assign flag_clr = (wr_acc && paddr == IPID_OFS_FLAGS) ? pwdata[3:0] : 4'h0; // R11

  // ----------------------------------------------------------------
  // pin synchroniser: three flops, change taken when 2nd and 3rd agree
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
    end else begin
      sync1_ff <= input_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // accepted level; frozen while inputs are deactivated in sleep
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_level_ff <= 4'h0;
    end else if (inputs_active) begin // R3
      for (int i = 0; i < IPID_PINS; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin // R19
          pin_level_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // debounce tap divider and two-tick stability filter
  // ----------------------------------------------------------------
  // divider restarts on wrap; a select change takes effect within one period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tap_cnt_ff <= 32'h0;
    end else if (tap_tick) begin
      tap_cnt_ff <= 32'h0;
    end else begin
      tap_cnt_ff <= tap_cnt_ff + 32'h1;
    end
  end

  // a level is accepted only when equal at two successive ticks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deb_samp_ff <= 4'h0;
      deb_ff <= 4'h0;
    end else if (tap_tick) begin
      deb_samp_ff <= pin_level_ff;
      for (int i = 0; i < IPID_PINS; i++) begin
        if (deb_samp_ff[i] == pin_level_ff[i]) begin // R5
          deb_ff[i] <= pin_level_ff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // edge detection and interrupt flags
  // ----------------------------------------------------------------
  // previous adjusted value; a polarity flip that raises a steady pin's adjusted value is an edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pol_prev_ff <= 4'hf; // no spurious edge straight out of reset
    end else begin
      pol_prev_ff <= pol_level; // R12 R19
    end
  end

  // sticky flags: write one clears, a same-cycle edge wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_ff <= IPID_RST_FLAGS; // R11
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | flag_set; // R10 R11
    end
  end

  // event status: any new flag, cleared by reading it, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_ff <= IPID_RST_EVT;
    end else if (rd_acc && paddr == IPID_OFS_EVT) begin
      evt_ff <= flag_set;
    end else begin
      evt_ff <= evt_ff | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // software-written configuration
  // ----------------------------------------------------------------
  // enables reset to zero on every reset, masking all pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enables_ff <= IPID_RST_ENABLES; // R9
    end else if (wr_acc && paddr == IPID_OFS_ENABLES) begin
      enables_ff <= pwdata[3:0];
    end
  end

  // remaining option registers, one field per pin except the two control bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      polarity_ff <= IPID_RST_POLARITY;
      bypass_ff <= IPID_RST_BYPASS;
      pulldis_ff <= IPID_RST_PULLDIS;
      ctrl_ff <= IPID_RST_CTRL;
      evtmask_ff <= IPID_RST_EVTMASK;
    end else if (wr_acc) begin
      unique case (paddr)
        IPID_OFS_POLARITY: polarity_ff <= pwdata[3:0]; // R2
        IPID_OFS_BYPASS: bypass_ff <= pwdata[3:0];     // R2
        IPID_OFS_PULLDIS: pulldis_ff <= pwdata[3:0];   // R2
        IPID_OFS_CTRL: ctrl_ff <= pwdata[1:0];
        IPID_OFS_EVTMASK: evtmask_ff <= pwdata[3:0];
        default: ; // other offsets handled elsewhere or ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave: answers in the cycle after setup, error on unmapped
  // ----------------------------------------------------------------
  always_comb begin
    nxt_prdata = 32'h0;
    unique case (paddr)
      IPID_OFS_LEVELS: nxt_prdata[3:0] = pin_level_ff; // R1
      IPID_OFS_ENABLES: nxt_prdata[3:0] = enables_ff;
      IPID_OFS_FLAGS: nxt_prdata[3:0] = flags_ff;
      IPID_OFS_POLARITY: nxt_prdata[3:0] = polarity_ff;
      IPID_OFS_BYPASS: nxt_prdata[3:0] = bypass_ff;
      IPID_OFS_PULLDIS: nxt_prdata[3:0] = pulldis_ff;
      IPID_OFS_CTRL: nxt_prdata[1:0] = ctrl_ff;
      IPID_OFS_EVT: nxt_prdata[3:0] = evt_ff;
      IPID_OFS_EVTMASK: nxt_prdata[3:0] = evtmask_ff;
      default: nxt_prdata = 32'h0;
    endcase
  end

  // data captured in setup so it is stable for the whole access phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin-side outputs, all from flops
  // ----------------------------------------------------------------
  // pulls on only if fitted, not disabled, and not in plain sleep
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pullup_ff <= 4'h0;
      pulldown_ff <= 4'h0;
    end else begin
      // both mask options fitted is illegal; neither pull is driven then
      pullup_ff <= PULLUP_MASK & ~PULLDN_MASK & ~pulldis_ff & {4{inputs_active}}; // R14 R3
      pulldown_ff <= PULLDN_MASK & ~PULLUP_MASK & ~pulldis_ff & {4{inputs_active}}; // R14 R3
    end
  end

  // wake request while sleeping with wake enabled and inputs matching
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= sleep_mode & ctrl_ff[IPID_CTRL_WAKE] & reset_match; // R4
    end
  end

  // feeds to the cpu branch inputs and counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      branch_ff <= 3'h0;
      evclk_ff <= 2'h0;
      msc_ff <= 1'b0;
    end else begin
      branch_ff <= deb_ff[2:0];                 // R15
      evclk_ff <= {pol_level[3], pol_level[0]}; // R16
      msc_ff <= pin_level_ff[3];                // R17
    end
  end

  // single level interrupt: enabled flags or unmasked event status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (|(flags_ff & enables_ff)) | (|(evt_ff & evtmask_ff)); // R18
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pullup_en = pullup_ff;
  assign pulldown_en = pulldown_ff;
  assign wake = wake_ff;
  assign branch_condition = branch_ff;
  assign event_clock = evclk_ff;
  assign millisecond_counter_ctl = msc_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  enables_reset_a: assert property (@(posedge core_clk) // R9
    $fell(rst) |-> enables_ff == 4'h0)
    else $error("enables not cleared by reset");

  masked_edge_a: assert property (@(posedge core_clk) disable iff (rst) // R10
    (edge_seen[0] && !enables_ff[0] && !flags_ff[0]) |=> !flags_ff[0])
    else $error("masked edge set a flag");

  flag_set_a: assert property (@(posedge core_clk) disable iff (rst) // R10
    flag_set[1] |=> flags_ff[1])
    else $error("enabled edge did not set flag");

  w1c_clear_a: assert property (@(posedge core_clk) disable iff (rst) // R11
    (wr_acc && paddr == IPID_OFS_FLAGS && pwdata[2] && !flag_set[2]) |=> !flags_ff[2])
    else $error("write one did not clear flag");

  w0_keep_a: assert property (@(posedge core_clk) disable iff (rst) // R11
    (wr_acc && paddr == IPID_OFS_FLAGS && !pwdata[3] && flags_ff[3]) |=> flags_ff[3])
    else $error("write zero changed flag");

  polarity_flip_a: assert property (@(posedge core_clk) disable iff (rst) // R12
    (pol_level[0] && !$past(pol_level[0]) && enables_ff[0]) |=> flags_ff[0])
    else $error("adjusted edge lost");

  irq_follow_a: assert property (@(posedge core_clk) disable iff (rst) // R18
    (|(flags_ff & enables_ff)) |=> irq)
    else $error("irq missing for enabled flag");

  pull_sleep_a: assert property (@(posedge core_clk) disable iff (rst) // R3
    (sleep_mode && !ctrl_ff[IPID_CTRL_WAKE]) [*2] |-> pullup_en == 4'h0 && pulldown_en == 4'h0)
    else $error("pulls left on in sleep");

  pull_disable_a: assert property (@(posedge core_clk) disable iff (rst) // R14
    pulldis_ff[1] |=> !pullup_en[1] && !pulldown_en[1])
    else $error("disabled pull still on");

  wake_exit_a: assert property (@(posedge core_clk) disable iff (rst) // R4
    (sleep_mode && ctrl_ff[IPID_CTRL_WAKE] && reset_match) |=> wake)
    else $error("wake not raised");

  deb_stable_a: assert property (@(posedge core_clk) disable iff (rst) // R5
    (tap_tick && deb_samp_ff[0] != pin_level_ff[0]) |=> $stable(deb_ff[0]))
    else $error("unstable input accepted");

  branch_deb_a: assert property (@(posedge core_clk) disable iff (rst) // R15
    ##1 branch_condition == $past(deb_ff[2:0]))
    else $error("branch condition not debounced level");

  msc_raw_a: assert property (@(posedge core_clk) disable iff (rst) // R17
    ##1 millisecond_counter_ctl == $past(pin_level_ff[3]))
    else $error("millisecond control not raw pin");

endmodule

// >>> ipid_pin_driver.sv
// Purpose: far-side model of the switches wired to the four port pins
// Assumes: bench chooses per pin whether a switch drives or floats
// Notes: a floating pin follows the pull that the port switches on
`timescale 1ns/10ps
module ipid_pin_driver (
  input wire logic core_clk,
  input wire logic [3:0] drive_en,
  input wire logic [3:0] drive_val,
  input wire logic [3:0] pullup_en,
  input wire logic [3:0] pulldown_en,
  output logic [3:0] input_pins
);
  // ----------------------------------------------------------------
  // released pins
  // ----------------------------------------------------------------
  // no pull and no driver: toggle, so a stale level is never mistaken for data
  logic [3:0] float_ff = 4'h0;

  // toggling pattern for undriven, unpulled pins
  always @(posedge core_clk) begin
    float_ff <= ~float_ff;
  end

  // driver wins, then pull-up, then pull-down, then floating pattern
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (drive_en[i]) begin
        input_pins[i] = drive_val[i];
      end else if (pullup_en[i]) begin
        input_pins[i] = 1'b1;
      end else if (pulldown_en[i]) begin
        input_pins[i] = 1'b0;
      end else begin
        input_pins[i] = float_ff[i];
      end
    end
  end
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the four-pin interrupting input port
// Assumes: shortened debounce taps, APB answer within a bounded wait
// Notes: reads queue their expectation; a monitor compares on pready
`timescale 1ns/10ps
module tb_top;
  import ipid_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic reset_match = 1'b0;
  logic [3:0] drive_en = 4'hf;
  logic [3:0] drive_val = 4'h0;
  logic [3:0] input_pins, pullup_en, pulldown_en;
  logic [31:0] prdata;
  logic pready, pslverr, wake, millisecond_counter_ctl, irq;
  logic [2:0] branch_condition;
  logic [1:0] event_clock;
  logic [32:0] notes[$]; // {pslverr, prdata} expected per read
  int mismatches = 0;
  int checks_done = 0;
  logic [3:0] v;

  always #2 core_clk = ~core_clk;

  ipid_port #(.SLOW_CYC(8), .FAST_CYC(4)) uut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pins(input_pins),
    .sleep_mode(sleep_mode), .reset_match(reset_match), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .wake(wake), .branch_condition(branch_condition),
    .event_clock(event_clock), .millisecond_counter_ctl(millisecond_counter_ctl),
    .irq(irq));

  ipid_pin_driver pins_model (.core_clk(core_clk), .drive_en(drive_en),
    .drive_val(drive_val), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .input_pins(input_pins));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // read completions: oldest note against the answer
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) begin
        check("unexpected read", {pslverr, prdata}, 33'h0);
      end else begin
        check("apb read", {pslverr, prdata}, notes.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // apb master and waits
  // ----------------------------------------------------------------
  // one transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) notes.push_back(exp);
    @(posedge core_clk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(52));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // reset values of enables, flags, polarity, bypass and control, then an unmapped place
    apb(0, IPID_OFS_ENABLES, 0, 33'h0);
    apb(0, IPID_OFS_FLAGS, 0, 33'h0);
    apb(0, IPID_OFS_POLARITY, 0, 33'h0);
    apb(0, IPID_OFS_BYPASS, 0, 33'h0);
    apb(0, IPID_OFS_CTRL, 0, 33'h0);
    apb(0, 8'h40, 0, {1'b1, 32'h0});
    check("pulldown_en", pulldown_en, 33'hf);
    check("pullup_en", pullup_en, 33'h0);
    // random levels, pin 1 left to its pull-down; level register read only
    v = 4'($urandom);
    drive_en <= 4'hd;
    drive_val <= v;
    apb(1, IPID_OFS_LEVELS, 32'hf, 33'h0);
    waitc(6);
    apb(0, IPID_OFS_LEVELS, 0, {29'h0, v & 4'hd});
    drive_en <= 4'hf;
    drive_val <= 4'h0;
    // per-pin pull disable
    apb(1, IPID_OFS_PULLDIS, 32'h5, 33'h0);
    waitc(2);
    check("pulldown_en", pulldown_en, 33'ha);
    apb(1, IPID_OFS_PULLDIS, 32'h0, 33'h0);
    // direct inputs, pin 0 enabled, pin 1 masked
    apb(1, IPID_OFS_BYPASS, 32'hf, 33'h0);
    apb(1, IPID_OFS_ENABLES, 32'h1, 33'h0);
    drive_val <= 4'h3;
    waitc(8);
    apb(0, IPID_OFS_FLAGS, 0, 33'h1);
    check("irq", irq, 33'h1);
    apb(1, IPID_OFS_FLAGS, 32'h2, 33'h0);
    apb(0, IPID_OFS_FLAGS, 0, 33'h1);
    apb(1, IPID_OFS_FLAGS, 32'h1, 33'h0);
    apb(0, IPID_OFS_FLAGS, 0, 33'h0);
    apb(0, IPID_OFS_EVT, 0, 33'h1);
    waitc(2);
    check("irq", irq, 33'h0);
    // polarity flip on a low pin makes a request
    apb(1, IPID_OFS_ENABLES, 32'h4, 33'h0);
    apb(1, IPID_OFS_POLARITY, 32'h4, 33'h0);
    waitc(4);
    apb(0, IPID_OFS_FLAGS, 0, 33'h4);
    // masked while changing polarity, then a falling edge on pin 0
    apb(1, IPID_OFS_ENABLES, 32'h0, 33'h0);
    apb(1, IPID_OFS_POLARITY, 32'h5, 33'h0);
    apb(1, IPID_OFS_FLAGS, 32'hf, 33'h0);
    apb(1, IPID_OFS_ENABLES, 32'h1, 33'h0);
    apb(0, IPID_OFS_FLAGS, 0, 33'h0);
    drive_val <= 4'h2;
    waitc(8);
    apb(0, IPID_OFS_FLAGS, 0, 33'h1);
    apb(1, IPID_OFS_FLAGS, 32'hf, 33'h0);
    apb(0, IPID_OFS_EVT, 0, 33'h5);
    // debounced pin 3, slow tap
    apb(1, IPID_OFS_POLARITY, 32'h0, 33'h0);
    apb(1, IPID_OFS_BYPASS, 32'h0, 33'h0);
    apb(1, IPID_OFS_ENABLES, 32'h8, 33'h0);
    drive_val <= 4'ha;
    waitc(6);
    check("irq early", irq, 33'h0);
    check("ms ctl", millisecond_counter_ctl, 33'h1);
    for (int n = 0; n < 60 && irq !== 1'b1; n++) waitc(1);
    check("irq debounced", irq, 33'h1);
    // a wait that ran out has been counted; go straight to the report
    if (irq !== 1'b1) begin
      summarize();
    end
    check("event clock", event_clock, 33'h2);
    waitc(30);
    check("branch", branch_condition, 33'h2);
    apb(1, IPID_OFS_FLAGS, 32'hf, 33'h0);
    // event status alone drives irq once unmasked; reading it drops irq
    apb(1, IPID_OFS_EVTMASK, 32'h8, 33'h0);
    waitc(2);
    check("irq event", irq, 33'h1);
    apb(0, IPID_OFS_EVT, 0, 33'h8);
    waitc(2);
    check("irq event clear", irq, 33'h0);
    apb(1, IPID_OFS_CTRL, 32'h1, 33'h0);
    apb(0, IPID_OFS_CTRL, 0, 33'h1);
    // sleep without, then with, the wake option
    sleep_mode <= 1'b1;
    reset_match <= 1'b1;
    waitc(3);
    check("sleep pulls", pulldown_en, 33'h0);
    check("wake", wake, 33'h0);
    apb(1, IPID_OFS_CTRL, 32'h2, 33'h0);
    waitc(3);
    check("wake pulls", pulldown_en, 33'hf);
    check("wake", wake, 33'h1);
    // reset in mid-run: enables set before must come back masked
    @(posedge core_clk);
    sleep_mode <= 1'b0;
    reset_match <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    apb(0, IPID_OFS_ENABLES, 0, 33'h0);
    apb(0, IPID_OFS_FLAGS, 0, 33'h0);
    waitc(2);
    check("wake after reset", wake, 33'h0);
    summarize();
  end
endmodule
